// [rtl/cvid_pkg.sv]
// Purpose: Constants for the core voltage identification block.
// Assumes: 40 MHz clock, 5-bit voltage codes.
// Notes:   Voltages are held in millivolts.
package cvid_pkg;
  // ===========================================================================
  // Code layout
  localparam int          CVID_CODE_W        = 5;
  localparam int          CVID_MV_W          = 12;
  localparam int          CVID_TOP_BIT       = 4;
  localparam logic [4:0]  CVID_SHUT_LO       = 5'h0F;
  localparam logic [4:0]  CVID_SHUT_HI       = 5'h1F;
  // ===========================================================================
  // Voltage map
  localparam logic [11:0] CVID_LO_BASE_MV    = 12'h7D0;
  localparam logic [11:0] CVID_LO_STEP_MV    = 12'h032;
  localparam logic [11:0] CVID_HI_BASE_MV    = 12'h4FB;
  localparam logic [11:0] CVID_HI_STEP_MV    = 12'h019;
  // ===========================================================================
  // Status field reset value (maximum-voltage code); plain default.
  localparam logic [4:0]  CVID_MAX_CODE_RST  = 5'h00;
  // ===========================================================================
  // Timing
  localparam int          CVID_CLK_PERIOD_PS = 25000;
  localparam int          CVID_DRIVE_MAX_PS  = 20000;
  localparam int          CVID_DRIVE_CYC_RAW = CVID_DRIVE_MAX_PS / CVID_CLK_PERIOD_PS;
  localparam int          CVID_DRIVE_CYC     = (CVID_DRIVE_CYC_RAW < 1) ? 1 : CVID_DRIVE_CYC_RAW;
endpackage

// [rtl/cvid_select.sv]
// Purpose: Processor-side voltage identification logic for the core supply.
// Assumes: power_good and reset come from outside the clock domain.
// Notes:   The driven code is only meaningful once power_good is high.
`timescale 1ns/1ps
// What this block does
// - Drive maximum-voltage code on the third clock edge after power-good rises.
// - Reset forces maximum-voltage code.
// - Top-bit-clear codes: 2.000 V down 50 mV.
// - Top-bit-set codes: 1.275 V down 25 mV.
// - Codes 01111 and 11111 mean shutdown.
// - Start-up and maximum fields report same code.
// - Code may change later through transition protocol.
module cvid_select
  import cvid_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   power_good_in,
  input  wire logic                   cpu_reset_n_in,
  input  wire logic [CVID_CODE_W-1:0] max_code_in,
  input  wire logic                   perf_req_in,
  input  wire logic [CVID_CODE_W-1:0] perf_code_in,
  output logic      [CVID_CODE_W-1:0] driven_voltage_code_out,
  output logic                        driven_valid_out,
  output logic      [CVID_CODE_W-1:0] startup_code_out,
  output logic      [CVID_CODE_W-1:0] max_field_out,
  output logic      [CVID_MV_W-1:0]   voltage_mv_out,
  output logic                        shutdown_out
);

  // ===========================================================================
  // Input synchronisers
  // Power-good, processor reset and the transition request come from pins that
  // bear no relation to clk_in, so each passes two flip-flops before logic reads it.
  // Processor reset is inverted first, so every flop resets to the idle level of its pin.
  localparam int SYNC_N    = 3;
  localparam int SYNC_PG   = 0;
  localparam int SYNC_RST  = 1;
  localparam int SYNC_PERF = 2;

  logic [SYNC_N-1:0] sync_raw;
  logic [SYNC_N-1:0] sync_out;
  logic              pg_sync;
  logic              rst_sync;
  logic              perf_sync;

  assign sync_raw[SYNC_PG]   = power_good_in;
  assign sync_raw[SYNC_RST]  = ~cpu_reset_n_in;
  assign sync_raw[SYNC_PERF] = perf_req_in;

  for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
    logic meta;
    logic held;

    // The first flop may go metastable; only the second flop reads it.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        meta <= 1'b0;
      end else begin
        meta <= sync_raw[g];
      end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        held <= 1'b0;
      end else begin
        held <= meta;
      end
    end

    assign sync_out[g] = held;
  end

  assign pg_sync   = sync_out[SYNC_PG];
  assign rst_sync  = sync_out[SYNC_RST];
  assign perf_sync = sync_out[SYNC_PERF];

  // ===========================================================================
  // Status field
  // The maximum code is captured once power is good and held; both fields read it.
  logic [CVID_CODE_W-1:0] max_field;
  logic                   max_taken;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      max_field <= CVID_MAX_CODE_RST;
      max_taken <= 1'b0;
    end else if (pg_sync && !max_taken) begin
      max_field <= max_code_in;
      max_taken <= 1'b1;
    end
  end

  // Both fields are loaded from the one captured value, so they can never differ.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      startup_code_out <= CVID_MAX_CODE_RST;
    end else begin
      startup_code_out <= max_field;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      max_field_out <= CVID_MAX_CODE_RST;
    end else begin
      max_field_out <= max_field;
    end
  end

  // ===========================================================================
  // Driven code
  logic                   pg_prev;
  logic [CVID_CODE_W-1:0] next_code;
  logic                   pg_rise;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pg_prev <= 1'b0;
    end else begin
      pg_prev <= pg_sync;
    end
  end

  assign pg_rise = pg_sync && !pg_prev;

  // Reset wins over a power-good rise, and both win over a transition request.
  // Before the first capture the maximum code is taken straight from its source.
  logic                   max_load;
  logic                   perf_take;
  logic [CVID_CODE_W-1:0] max_source;

  assign max_load   = rst_sync || pg_rise;
  assign perf_take  = perf_sync && pg_sync && !rst_sync;
  assign max_source = max_taken ? max_field : max_code_in;

  always_comb begin
    next_code = driven_voltage_code_out;
    if (max_load) begin
      next_code = max_source;
    end else if (perf_take) begin
      next_code = perf_code_in;
    end
  end

  // The code is registered at the output; the synchronisers add two cycles on power_good.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      driven_voltage_code_out <= CVID_MAX_CODE_RST;
    end else begin
      driven_voltage_code_out <= next_code;
    end
  end

  // Valid follows the synchronised power-good, so it drops again when power goes away.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      driven_valid_out <= 1'b0;
    end else begin
      driven_valid_out <= pg_sync;
    end
  end

  // ===========================================================================
  // Code to voltage map
  logic [CVID_MV_W-1:0] next_mv;
  logic [CVID_MV_W-1:0] steps;
  logic                 next_shut;

  always_comb begin
    steps     = {8'h00, 4'(next_code[3:0])};
    next_shut = (next_code == CVID_SHUT_LO) || (next_code == CVID_SHUT_HI);
    if (next_shut) begin
      next_mv = 12'h000;
    end else if (!next_code[CVID_TOP_BIT]) begin
      next_mv = CVID_LO_BASE_MV - 12'(steps * CVID_LO_STEP_MV);
    end else begin
      next_mv = CVID_HI_BASE_MV - 12'(steps * CVID_HI_STEP_MV);
    end
  end

  // The map is fed from the next code, so voltage and code change on the same edge.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      voltage_mv_out <= CVID_LO_BASE_MV;
    end else begin
      voltage_mv_out <= next_mv;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shutdown_out <= 1'b0;
    end else begin
      shutdown_out <= next_shut;
    end
  end

endmodule

// [tb/cvid_checker.sv]
// Purpose: Assertions on the voltage code outputs.
// Assumes: Ports of cvid_select only.
// Notes:   Bound at the foot.
`timescale 1ns/1ps
module cvid_checker import cvid_pkg::*; (
  input wire logic        clk_in, reset_n_in, power_good_in, cpu_reset_n_in, perf_req_in,
  input wire logic [4:0]  max_code_in, perf_code_in, driven_voltage_code_out,
  input wire logic [4:0]  startup_code_out, max_field_out,
  input wire logic        driven_valid_out, shutdown_out,
  input wire logic [11:0] voltage_mv_out
);
  wire logic [4:0] c = driven_voltage_code_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================================
  // Checks
  property p_drive; $rose(power_good_in) ##0 (!perf_req_in)[*3] |-> ##1 c == max_code_in
    && driven_valid_out ##1 max_field_out == max_code_in; endproperty
  a_drive: assert property (p_drive) else $error("max code late");
  property p_rst; (power_good_in && !cpu_reset_n_in)[*4] |-> c == max_code_in; endproperty
  a_rst: assert property (p_rst) else $error("reset code wrong");
  property p_lo; !c[4] && !shutdown_out |-> voltage_mv_out == CVID_LO_BASE_MV - CVID_LO_STEP_MV * c;
  endproperty
  a_lo: assert property (p_lo) else $error("low map wrong");
  property p_hi; c[4] && !shutdown_out |-> voltage_mv_out == CVID_HI_BASE_MV
    - CVID_HI_STEP_MV * c[3:0]; endproperty
  a_hi: assert property (p_hi) else $error("high map wrong");
  property p_shut; shutdown_out == (&c[3:0]) && shutdown_out == (voltage_mv_out == 12'h000);
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown wrong");
  property p_same; startup_code_out == max_field_out; endproperty
  a_same: assert property (p_same) else $error("fields differ");
  property p_perf; (perf_req_in && power_good_in && cpu_reset_n_in)[*6] |-> c == perf_code_in;
  endproperty
  a_perf: assert property (p_perf) else $error("transition code");
  property p_valid; driven_valid_out == $past(power_good_in, 3); endproperty
  a_valid: assert property (p_valid) else $error("valid timing");
  cover property (perf_req_in && driven_valid_out ##3 shutdown_out);
  cover property ($rose(driven_valid_out));
  cover property (shutdown_out);
  cover property (!cpu_reset_n_in && driven_valid_out);
endmodule
bind cvid_select cvid_checker cvid_checker_inst (.*);

// [tb/cvid_board_mux.sv]
// Purpose: Board selector feeding the core supply converter.
// Assumes: Level power-good, no clock.
// Notes:   Behavioural.
`timescale 1ns/1ps
module cvid_board_mux (
  input  wire logic       power_good_in,
  input  wire logic [4:0] strap_in,
  input  wire logic [4:0] driven_in,
  output logic      [4:0] supply_code_out
);
  // The driven code is undefined before power-good, so the strap is used then.
  assign supply_code_out = power_good_in ? driven_in : strap_in;
endmodule

// [tb/test_cvid_select.sv]
// Purpose: Self-checking bench for cvid_select.
// Assumes: Inputs change at falling edges.
// Notes:   Max code 5'h02, strap 5'h03.
`timescale 1ns/1ps
module test_cvid_select import cvid_pkg::*;;
  logic        clk = 0, rst_n = 0, pg = 0, cpu_rst_n = 1, perf = 0, valid, shut;
  logic [4:0]  pcode = 5'h00, code, start_f, max_f, sup;
  logic [11:0] mv;
  int          n_errors = 0, n_checks = 0;
  localparam logic [4:0] MAXC = 5'h02, STRAP = 5'h03;
  always #12.5 clk = ~clk;
  cvid_select cvid_select_inst (.clk_in(clk), .reset_n_in(rst_n), .power_good_in(pg),
    .cpu_reset_n_in(cpu_rst_n), .max_code_in(MAXC), .perf_req_in(perf), .perf_code_in(pcode),
    .driven_voltage_code_out(code), .driven_valid_out(valid), .startup_code_out(start_f),
    .max_field_out(max_f), .voltage_mv_out(mv), .shutdown_out(shut));
  cvid_board_mux cvid_board_mux_inst (.power_good_in(pg), .strap_in(STRAP), .driven_in(code),
    .supply_code_out(sup));
  // ==========================================================================
  // Tasks
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic power_up;
    chk("supply", 12'(STRAP), 12'(sup));
    chk("valid", 12'h000, 12'(valid));
    pg = 1;
    repeat (4) @(negedge clk);
    chk("code", 12'(MAXC), 12'(code));
    chk("valid", 12'h001, 12'(valid));
    chk("supply", 12'(MAXC), 12'(sup));
    @(negedge clk);
    chk("max field", 12'(MAXC), 12'(max_f));
    chk("start field", 12'(MAXC), 12'(start_f));
  endtask
  task automatic perf_walk;
    logic [4:0] t[6] = '{5'h00, 5'h0E, 5'h10, 5'h1F, 5'h0F, 5'h1E};
    foreach (t[i]) begin
      pcode = t[i];
      perf = 1;
      repeat (6) @(negedge clk);
      chk("code", 12'(t[i]), 12'(code));
      chk("mv", (&t[i][3:0]) ? 12'h000 : t[i][4] ? CVID_HI_BASE_MV - CVID_HI_STEP_MV * t[i][3:0]
        : CVID_LO_BASE_MV - CVID_LO_STEP_MV * t[i], mv);
      chk("shutdown", 12'(&t[i][3:0]), 12'(shut));
      perf = 0;
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic reset_drop;
    cpu_rst_n = 0;
    perf = 1;
    repeat (4) @(negedge clk);
    chk("code", 12'(MAXC), 12'(code));
    cpu_rst_n = 1;
    perf = 0;
    pg = 0;
    @(negedge clk);
    chk("supply", 12'(STRAP), 12'(sup));
    repeat (3) @(negedge clk);
    chk("valid", 12'h000, 12'(valid));
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    power_up();
    perf_walk();
    reset_drop();
    tally_and_finish();
  end
  initial begin
    #(400 * 25);
    n_errors++;
    tally_and_finish();
  end
endmodule
